// >>> design/trpc_pkg.sv
// Constants and types for the transmit-request pin control block
package trpc_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] TRPC_PIN_CTRL_ADDR = 8'h0d;
    localparam logic [7:0] TRPC_ID_HIGH0_ADDR = 8'h31;
    localparam logic [7:0] TRPC_ID_HIGH1_ADDR = 8'h41;
    localparam logic [7:0] TRPC_ID_HIGH2_ADDR = 8'h51;

    // ****************************************
    // Field layout of the pin control register
    // ****************************************
    localparam int TRPC_MODE_LSB = 0;
    localparam int TRPC_LEVEL_LSB = 3;
    localparam int TRPC_NUM_PINS = 3;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [2:0] TRPC_MODE_RESET = 3'h0;
    localparam logic [7:0] TRPC_ID_RESET = 8'h00;
    localparam logic TRPC_PIN_IDLE = 1'b1;
    localparam logic [7:0] TRPC_UNMAPPED_READ = 8'h00;

    // Register access from the host port
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } trpc_req_t;

endpackage

// >>> design/trpc_top.sv
// Transmit-request pin control and upper standard identifier bytes
`timescale 1ns/1ps
`default_nettype none
module trpc_top
    import trpc_pkg::*;
#(
    parameter int NUM_PINS = 3
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Register access
    input var trpc_pkg::trpc_req_t reg_req,
    output logic [7:0] reg_rdata,
    // Active-low request pins
    input wire logic [NUM_PINS-1:0] send_request_pin_n,
    // Transmit engine side
    input wire logic [NUM_PINS-1:0] msg_sent,
    output logic [NUM_PINS-1:0] pending_send_flag,
    output logic [NUM_PINS-1:0][7:0] std_identifier_upper
);
    import trpc_pkg::*;

    // ****************************************
    // Register state
    // ****************************************
    logic [NUM_PINS-1:0] pin_mode;
    logic [NUM_PINS-1:0] sync_a;
    logic [NUM_PINS-1:0] sync_b;
    logic [NUM_PINS-1:0] pin_prev;
    logic [NUM_PINS-1:0] fall_req;
    logic [NUM_PINS-1:0] next_pending;
    logic [NUM_PINS-1:0] pin_level;
    logic [NUM_PINS-1:0] id_wr;
    logic ctrl_sel;
    logic [7:0] ctrl_view;
    logic [7:0] next_rdata;
    logic [7:0] id_addr [NUM_PINS];

    assign id_addr[0] = TRPC_ID_HIGH0_ADDR;
    assign id_addr[1] = TRPC_ID_HIGH1_ADDR;
    assign id_addr[2] = TRPC_ID_HIGH2_ADDR;

    // ****************************************
    // Decode
    // ****************************************
    // Control register decode
    assign ctrl_sel = (reg_req.addr == TRPC_PIN_CTRL_ADDR);

    // Level forced low in request mode
    assign pin_level = sync_b & ~pin_mode;

    assign ctrl_view = {2'b00, pin_level, pin_mode};

    // Falling edge only in request mode
    assign fall_req = pin_prev & ~sync_b & pin_mode;

    // Sent clears, a new edge wins
    assign next_pending = fall_req | (pending_send_flag & ~msg_sent);

    always_comb
    begin
        next_rdata = TRPC_UNMAPPED_READ;
        if (ctrl_sel)
        begin
            next_rdata = ctrl_view;
        end
        for (int i = 0; i < NUM_PINS; i++)
        begin
            if (reg_req.addr == id_addr[i])
            begin
                next_rdata = std_identifier_upper[i];
            end
        end
    end

    // ****************************************
    // Control register and read data
    // ****************************************
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pin_mode <= TRPC_MODE_RESET[NUM_PINS-1:0];
            reg_rdata <= TRPC_UNMAPPED_READ;
        end
        else
        begin
            if (reg_req.wr && ctrl_sel)
            begin
                pin_mode <= reg_req.wdata[TRPC_MODE_LSB +: NUM_PINS];
            end
            if (reg_req.rd)
            begin
                reg_rdata <= next_rdata;
            end
        end
    end

    // ****************************************
    // Per-pin logic
    // ****************************************
    // Pins idle high so reset never fakes an edge
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sync_a <= {NUM_PINS{TRPC_PIN_IDLE}};
            sync_b <= {NUM_PINS{TRPC_PIN_IDLE}};
            pin_prev <= {NUM_PINS{TRPC_PIN_IDLE}};
            pending_send_flag <= '0;
        end
        else
        begin
            sync_a <= send_request_pin_n;
            sync_b <= sync_a;
            pin_prev <= sync_b;
            pending_send_flag <= next_pending;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++)
        begin : g_id
            assign id_wr[g] = reg_req.wr && (reg_req.addr == id_addr[g]);

            always_ff @(posedge core_clk or negedge rstn)
            begin
                if (!rstn)
                begin
                    std_identifier_upper[g] <= TRPC_ID_RESET;
                end
                else if (id_wr[g])
                begin
                    std_identifier_upper[g] <= reg_req.wdata;
                end
            end
        end
    endgenerate

    // ****************************************
    // Assertions
    // ****************************************
    ctrl_read_layout_a:
    assert property (@(posedge core_clk) disable iff (!rstn)
        reg_req.rd && ctrl_sel |=> reg_rdata[7:6] == 2'b00
            && reg_rdata[2:0] == $past(pin_mode))
    else $error("Control register read layout wrong");

    level_in_input_a:
    assert property (@(posedge core_clk) disable iff (!rstn)
        reg_req.rd && ctrl_sel && !pin_mode[1] |=> reg_rdata[4] == $past(sync_b[1]))
    else $error("Pin level not reported in input mode");

    level_zero_rts_a:
    assert property (@(posedge core_clk) disable iff (!rstn)
        reg_req.rd && ctrl_sel |=> (reg_rdata[5:3] & $past(pin_mode)) == 3'b000)
    else $error("Level bit not zero in request mode");

    edge_sets_pend_a:
    assert property (@(posedge core_clk) disable iff (!rstn)
        $fell(sync_b[0]) && pin_mode[0] |=> pending_send_flag[0])
    else $error("Falling edge did not raise request");

    input_mode_quiet_a:
    assert property (@(posedge core_clk) disable iff (!rstn)
        !pin_mode[0] && !pending_send_flag[0] |=> !pending_send_flag[0])
    else $error("Request raised in input mode");

    id_write_hold_a:
    assert property (@(posedge core_clk) disable iff (!rstn)
        id_wr[2] |=> std_identifier_upper[2] == $past(reg_req.wdata))
    else $error("Identifier byte not stored");

    sent_clears_a:
    assert property (@(posedge core_clk) disable iff (!rstn)
        |(msg_sent & ~fall_req) |=> (pending_send_flag & $past(msg_sent & ~fall_req)) == '0)
    else $error("Request not cleared after send");

    sync_delay_a:
    assert property (@(posedge core_clk) disable iff (!rstn)
        pin_mode[2] && $fell(send_request_pin_n[2]) ##1 pin_mode[2] ##1 pin_mode[2]
            |=> pending_send_flag[2])
    else $error("Request not raised three cycles after pin fall");

    // Set wins so a late sent pulse never loses a fresh edge
    set_wins_a:
    assert property (@(posedge core_clk) disable iff (!rstn)
        |fall_req |=> (pending_send_flag & $past(fall_req)) == $past(fall_req))
    else $error("New request lost to a sent pulse");

    pending_held_a:
    assert property (@(posedge core_clk) disable iff (!rstn)
        |(pending_send_flag & ~msg_sent) |=> (pending_send_flag & $past(pending_send_flag & ~msg_sent))
            == $past(pending_send_flag & ~msg_sent))
    else $error("Pending request dropped before send");

    input_quiet_all_a:
    assert property (@(posedge core_clk) disable iff (!rstn)
        |(~pin_mode & ~pending_send_flag) |=> (pending_send_flag & $past(~pin_mode & ~pending_send_flag)) == '0)
    else $error("Request raised on a pin in input mode");

    mode_write_a:
    assert property (@(posedge core_clk) disable iff (!rstn)
        reg_req.wr && ctrl_sel |=> pin_mode == $past(reg_req.wdata[TRPC_MODE_LSB +: NUM_PINS]))
    else $error("Mode bits not written");

    unmapped_write_a:
    assert property (@(posedge core_clk) disable iff (!rstn)
        reg_req.wr && !ctrl_sel && id_wr == '0 |=> $stable(pin_mode) && $stable(std_identifier_upper))
    else $error("Unmapped write changed a register");

    // Zero keeps gaps in the map harmless to scan
    unmapped_read_a:
    assert property (@(posedge core_clk) disable iff (!rstn)
        reg_req.rd && !ctrl_sel && reg_req.addr != TRPC_ID_HIGH0_ADDR && reg_req.addr != TRPC_ID_HIGH1_ADDR
            && reg_req.addr != TRPC_ID_HIGH2_ADDR |=> reg_rdata == TRPC_UNMAPPED_READ)
    else $error("Unmapped read not zero");

    id_read_back_a:
    assert property (@(posedge core_clk) disable iff (!rstn)
        reg_req.rd && reg_req.addr == TRPC_ID_HIGH1_ADDR |=> reg_rdata == $past(std_identifier_upper[1]))
    else $error("Identifier byte read back wrong");

    // Host may sample read data late, so it must stand
    rdata_hold_a:
    assert property (@(posedge core_clk) disable iff (!rstn)
        !reg_req.rd |=> $stable(reg_rdata))
    else $error("Read data changed without a read");

endmodule
`default_nettype wire

// >>> verif/trpc_host.sv
// Host model: register accesses, request pins, sent pulses
`timescale 1ns/1ps
`default_nettype none
module trpc_host
    import trpc_pkg::*;
(
    // Clock and read data
    input wire logic core_clk,
    input wire logic [7:0] reg_rdata,
    // Host drives
    output var trpc_pkg::trpc_req_t reg_req = '0,
    output logic [2:0] pin_n = 3'h7,
    output logic [2:0] sent = 3'h0
);
    import trpc_pkg::*;

    // Released data inverted so a stale byte never passes
    task automatic access(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
        @(posedge core_clk);
        reg_req <= '{a, w, !w, d};
        @(posedge core_clk);
        reg_req <= '{8'h00, 1'b0, 1'b0, ~d};
        #1 q = reg_rdata;
    endtask
    task automatic step(input logic [2:0] p, input logic [2:0] s, input int n);
        @(posedge core_clk);
        pin_n <= p;
        sent <= s;
        @(posedge core_clk);
        sent <= 3'h0;
        repeat (n - 1) @(posedge core_clk);
        #1;
    endtask
endmodule
`default_nettype wire

// >>> verif/trpc_top_tb.sv
// Bench for the request pin control block
`timescale 1ns/1ps
`default_nettype none
module trpc_top_tb;
    import trpc_pkg::*;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    trpc_req_t reg_req;
    logic [7:0] reg_rdata;
    logic [7:0] q;
    logic [2:0] pin_n, sent, pend;
    logic [2:0][7:0] ids;
    int failures = 0;
    int checked = 0;
    trpc_top DUT (.core_clk, .rstn, .reg_req, .reg_rdata, .send_request_pin_n(pin_n), .msg_sent(sent),
        .pending_send_flag(pend), .std_identifier_upper(ids));
    trpc_host HOST (.core_clk, .reg_rdata, .reg_req, .pin_n(pin_n), .sent(sent));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("failures %0d checked %0d", failures, checked);
        if (failures == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Distinct byte per buffer catches crossed decodes
    task automatic id_bytes;
        logic [7:0] adr [3];
        adr = '{TRPC_ID_HIGH0_ADDR, TRPC_ID_HIGH1_ADDR, TRPC_ID_HIGH2_ADDR};
        for (int i = 0; i < 3; i++)
            HOST.access(adr[i], 1'b1, 8'hc3 ^ 8'(i), q);
        HOST.access(8'h32, 1'b1, 8'h5a, q);
        for (int i = 0; i < 3; i++)
        begin
            HOST.access(adr[i], 1'b0, 8'h00, q);
            check(q, 8'hc3 ^ 8'(i));
            check(ids[i], 8'hc3 ^ 8'(i));
        end
        HOST.access(8'h32, 1'b0, 8'h00, q);
        check(q, 8'h00);
    endtask
    task automatic pin_levels;
        HOST.access(TRPC_PIN_CTRL_ADDR, 1'b0, 8'h00, q);
        check(q, 8'h38);
        HOST.step(3'b101, 3'h0, 3);
        HOST.access(TRPC_PIN_CTRL_ADDR, 1'b0, 8'h00, q);
        check(q, 8'h28);
        // High pins in request mode must read zero; pin 1 is low when armed
        HOST.access(TRPC_PIN_CTRL_ADDR, 1'b1, 8'hff, q);
        HOST.access(TRPC_PIN_CTRL_ADDR, 1'b0, 8'h00, q);
        check(q, 8'h07);
        check(8'(pend), 8'h00);
    endtask
    task automatic request;
        HOST.access(TRPC_PIN_CTRL_ADDR, 1'b1, 8'h07, q);
        HOST.step(3'b111, 3'h0, 3);
        HOST.step(3'b010, 3'h0, 2);
        check(8'(pend), 8'h00);
        @(posedge core_clk);
        #1;
        check(8'(pend), 8'h05);
        HOST.step(3'b010, 3'b001, 1);
        check(8'(pend), 8'h04);
        // Sent pulse lands on the edge that takes a new fall
        HOST.step(3'b011, 3'h0, 2);
        HOST.step(3'b010, 3'h0, 1);
        HOST.step(3'b010, 3'b001, 1);
        check(8'(pend), 8'h05);
        HOST.access(TRPC_PIN_CTRL_ADDR, 1'b1, 8'h00, q);
        HOST.step(3'b111, 3'b101, 3);
        HOST.step(3'b000, 3'h0, 5);
        check(8'(pend), 8'h00);
        HOST.access(TRPC_PIN_CTRL_ADDR, 1'b0, 8'h00, q);
        check(q, 8'h00);
    endtask
    initial
        forever #50 core_clk = ~core_clk;
    initial
    begin
        repeat (10) @(posedge core_clk);
        rstn <= 1'b1;
        pin_levels();
        id_bytes();
        request();
        complete_run();
    end
    // Run needs about 70 cycles; allow a thousand
    initial
    begin
        #100000;
        failures++;
        complete_run();
    end
endmodule
`default_nettype wire
